// [fmx_dec_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------
// Decoder stand-in, master of the register bus
// ------------------------------------------------
module fmx_dec_model (
  // Clock
  input  wire logic        ref_clk,
  // Avalon-MM master side
  output logic      [11:0] avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  // Bus idle at time zero
  initial begin
    avs_address   = 12'h000;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h00000000;
  end

  // One access, held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk);
    avs_address   <= a;
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_writedata <= d;
    // No cycle limit here: only the bench watchdog may end a hung access
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
    q = avs_readdata;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_writedata <= ~d;  // Released data never repeats the last value
  endtask : xfer
endmodule : fmx_dec_model

// [fmx_defines.svh]
`ifndef FMX_DEFINES_SVH
`define FMX_DEFINES_SVH
// Contract
// - OR working register with addressed file (0..127); zero flag from result.
// - Destination bit 0 writes working register, 1 writes addressed file back.
// - Move-file copies file unchanged to chosen destination, file may rewrite itself.
// - Move-file updates zero flag from moved value, allowing non-destructive test.
// - Store-working copies working register to file, leaves every flag unchanged.
// - Rotate-left through carry: old carry into bit 0, old bit 7 out.

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FMX_OFF_INSTR  12'h000
`define FMX_OFF_WORK   12'h004
`define FMX_OFF_STATUS 12'h008
`define FMX_OFF_PC     12'h00c
`define FMX_OFF_STACK  12'h010
`define FMX_OFF_GIE    12'h014
`define FMX_FILE_BASE  3'h1
// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define FMX_INSTR_D    7
`define FMX_INSTR_OPLO 8
`define FMX_INSTR_OPHI 10
`define FMX_STAT_C     0
`define FMX_STAT_Z     2
`define FMX_RST_BYTE   8'h00
`define FMX_RST_INSTR  11'h000
`endif

// [fmx_exec.sv]
`timescale 1ns/1ps
`include "fmx_defines.svh"
module fmx_exec
  import fmx_pkg::*;
#(
  parameter int PC_W       = 13,
  parameter int FILE_DEPTH = 128
) (
  // Clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rstn,
  // Avalon-MM slave
  input  wire logic [11:0]     avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  output logic      [31:0]     avs_readdata,
  output logic                 avs_waitrequest,
  // Core state
  output logic      [PC_W-1:0] pcOut,
  output logic                 globalIntEnable,
  output logic                 execBusy
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Word address match on one register offset
  function automatic logic isOff(input logic [11:0] a, input logic [11:0] o);
    isOff = (a[11:2] == o[11:2]);
  endfunction : isOff

  // Ops that write a selectable destination
  function automatic logic hasDest(input fmx_op_t o);
    hasDest = (o == or_working_into_file) || (o == move_file_to_dest) ||
              (o == rotate_left_through_carry);
  endfunction : hasDest

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fmx_state_t      state_ff;
  fmx_state_t      nxt_state;
  logic [10:0]     instr_ff;
  logic [7:0]      workReg_ff;
  logic            carry_ff;
  logic            zero_ff;
  logic [PC_W-1:0] pc_ff;
  logic [PC_W-1:0] stackTop_ff;
  logic            gie_ff;
  logic            phase_ff;
  logic [31:0]     rdata_ff;
  logic [7:0]      fileMem [FILE_DEPTH];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        stIdle   = (state_ff == FMX_IDLE);
  wire        stExec   = (state_ff == FMX_EXEC);
  wire        busReq   = avs_read | avs_write;
  // Two-cycle answer: first cycle fetches read data, second acks
  wire        busAck   = busReq & stIdle & phase_ff;
  wire        wAcc     = avs_write & busAck;
  wire        hitInstr = isOff(avs_address, `FMX_OFF_INSTR);
  wire        hitWork  = isOff(avs_address, `FMX_OFF_WORK);
  wire        hitStat  = isOff(avs_address, `FMX_OFF_STATUS);
  wire        hitPc    = isOff(avs_address, `FMX_OFF_PC);
  wire        hitStack = isOff(avs_address, `FMX_OFF_STACK);
  wire        hitGie   = isOff(avs_address, `FMX_OFF_GIE);
  wire        hitFile  = (avs_address[11:9] == `FMX_FILE_BASE);
  wire [6:0]  busIdx   = avs_address[8:2];
  wire [7:0]  statByte = (8'(carry_ff) << `FMX_STAT_C) | (8'(zero_ff) << `FMX_STAT_Z);

  // Read mux; unmapped words read as zero
  wire [31:0] rdMux =
    hitInstr ? {21'h000000, instr_ff} :
    hitWork  ? {24'h000000, workReg_ff} :
    hitStat  ? {24'h000000, statByte} :
    hitPc    ? 32'(pc_ff) :
    hitStack ? 32'(stackTop_ff) :
    hitGie   ? {31'h00000000, gie_ff} :
    hitFile  ? {24'h000000, fileMem[busIdx]} : 32'h00000000;

  assign avs_waitrequest = busReq & ~busAck;
  assign avs_readdata    = rdata_ff;
  assign pcOut           = pc_ff;
  assign globalIntEnable = gie_ff;
  assign execBusy        = stExec;

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  wire [6:0]  fAddr   = instr_ff[6:0];
  wire        dSel    = instr_ff[`FMX_INSTR_D];
  wire fmx_op_t op    = fmx_op_t'(instr_ff[`FMX_INSTR_OPHI:`FMX_INSTR_OPLO]);
  wire [7:0]  opnd    = fileMem[fAddr];
  wire [7:0]  orRes   = workReg_ff | opnd;
  wire [7:0]  rlRes   = {opnd[6:0], carry_ff};
  wire [7:0]  result  = (op == or_working_into_file) ? orRes :
                        (op == rotate_left_through_carry) ? rlRes :
                        opnd;
  // Destination select
  wire        wrWork  = stExec & hasDest(op) & ~dSel;
  wire        wrFile  = stExec & ((hasDest(op) & dSel) |
                        (op == store_working_to_file));
  wire [7:0]  fileVal = (op == store_working_to_file) ? workReg_ff : result;
  // Flags: only OR and move touch zero, only rotate touches carry
  wire        updZ    = stExec & ((op == or_working_into_file) |
                        (op == move_file_to_dest));
  wire        updC    = stExec & (op == rotate_left_through_carry);
  wire        doRet   = stExec & (op == return_from_interrupt_op);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Instruction write starts one execute cycle; bus stalls meanwhile
  always_comb begin
    case (state_ff)
      FMX_IDLE: nxt_state = (wAcc & hitInstr) ? FMX_EXEC : FMX_IDLE;
      FMX_EXEC: nxt_state = FMX_IDLE;
      default:  nxt_state = FMX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= FMX_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Bus phase and registered read data
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      phase_ff <= busReq & stIdle & ~phase_ff;
      if (avs_read & stIdle & ~phase_ff) begin
        rdata_ff <= rdMux;
      end
    end
  end

  // Instruction register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      instr_ff <= `FMX_RST_INSTR;
    end else if (wAcc & hitInstr) begin
      instr_ff <= avs_writedata[10:0];
    end
  end

  // Working register: bus writes only land while idle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      workReg_ff <= `FMX_RST_BYTE;
    end else if (wrWork) begin
      workReg_ff <= result;
    end else if (wAcc & hitWork) begin
      workReg_ff <= avs_writedata[7:0];
    end
  end

  // Status flags
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      zero_ff  <= 1'b0;
      carry_ff <= 1'b0;
    end else begin
      if (updZ) begin
        zero_ff <= (result == 8'h00);
      end else if (wAcc & hitStat) begin
        zero_ff <= avs_writedata[`FMX_STAT_Z];
      end
      if (updC) begin
        carry_ff <= opnd[7];
      end else if (wAcc & hitStat) begin
        carry_ff <= avs_writedata[`FMX_STAT_C];
      end
    end
  end

  // Program counter, stack top and interrupt enable
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pc_ff       <= '0;
      stackTop_ff <= '0;
      gie_ff      <= 1'b0;
    end else begin
      if (doRet) begin
        pc_ff  <= stackTop_ff;
        gie_ff <= 1'b1;
      end else if (wAcc & hitGie) begin
        gie_ff <= avs_writedata[0];
      end
      if (wAcc & hitStack) begin
        stackTop_ff <= avs_writedata[PC_W-1:0];
      end
    end
  end

  // File registers have no reset; execute and bus never overlap
  always_ff @(posedge ref_clk) begin
    if (wrFile) begin
      fileMem[fAddr] <= fileVal;
    end else if (wAcc & hitFile) begin
      fileMem[busIdx] <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_or_work;
    @(posedge ref_clk) disable iff (!rstn)
    stExec && op == or_working_into_file && !dSel |=>
      workReg_ff == $past(orRes) && zero_ff == ($past(orRes) == 8'h00);
  endproperty
  a_or_work: assert property (p_or_work) else $error("OR result wrong");

  property p_or_file;
    @(posedge ref_clk) disable iff (!rstn)
    stExec && op == or_working_into_file && dSel |=>
      fileMem[$past(fAddr)] == $past(orRes) && $stable(workReg_ff);
  endproperty
  a_or_file: assert property (p_or_file) else $error("OR dest wrong");

  property p_one_exec;
    @(posedge ref_clk) disable iff (!rstn)
    wAcc && hitInstr |=> stExec ##1 stIdle;
  endproperty
  a_one_exec: assert property (p_one_exec) else $error("Exec not one cycle");

  property p_move_file_to_dest_self;
    @(posedge ref_clk) disable iff (!rstn)
    stExec && op == move_file_to_dest && dSel |=>
      fileMem[$past(fAddr)] == $past(opnd) && $stable(workReg_ff);
  endproperty
  a_move_file_to_dest_self: assert property (p_move_file_to_dest_self) else $error("Move altered file");

  property p_move_file_to_dest_zero;
    @(posedge ref_clk) disable iff (!rstn)
    stExec && op == move_file_to_dest |=>
      zero_ff == ($past(opnd) == 8'h00) && $stable(carry_ff);
  endproperty
  a_move_file_to_dest_zero: assert property (p_move_file_to_dest_zero) else $error("Move zero wrong");

  property p_store;
    @(posedge ref_clk) disable iff (!rstn)
    stExec && op == store_working_to_file |=>
      fileMem[$past(fAddr)] == $past(workReg_ff) && $stable(statByte);
  endproperty
  a_store: assert property (p_store) else $error("Store wrong");

  property p_rotate;
    @(posedge ref_clk) disable iff (!rstn)
    stExec && op == rotate_left_through_carry && !dSel |=>
      carry_ff == $past(opnd[7]) && workReg_ff == $past(rlRes) &&
      $stable(zero_ff);
  endproperty
  a_rotate: assert property (p_rotate) else $error("Rotate wrong");

  property p_or_flags;
    @(posedge ref_clk) disable iff (!rstn)
    stExec && op == or_working_into_file && dSel |=>
      zero_ff == ($past(orRes) == 8'h00) && $stable(carry_ff);
  endproperty
  a_or_flags: assert property (p_or_flags) else $error("OR flags wrong");

  property p_move_file_to_dest_work;
    @(posedge ref_clk) disable iff (!rstn)
    stExec && op == move_file_to_dest && !dSel |=>
      workReg_ff == $past(opnd) && fileMem[$past(fAddr)] == $past(opnd);
  endproperty
  a_move_file_to_dest_work: assert property (p_move_file_to_dest_work) else $error("Move to work wrong");

  property p_rot_file;
    @(posedge ref_clk) disable iff (!rstn)
    stExec && op == rotate_left_through_carry && dSel |=>
      fileMem[$past(fAddr)] == $past(rlRes) && carry_ff == $past(opnd[7]) &&
      $stable(workReg_ff) && $stable(zero_ff);
  endproperty
  a_rot_file: assert property (p_rot_file) else $error("Rotate dest wrong");

  property p_return;
    @(posedge ref_clk) disable iff (!rstn)
    stExec && op == return_from_interrupt_op |=>
      pc_ff == $past(stackTop_ff) && gie_ff && $stable(statByte);
  endproperty
  a_return: assert property (p_return) else $error("Return wrong");

  // Main scenarios
  c_or_file: cover property (@(posedge ref_clk) disable iff (!rstn)
    stExec && op == or_working_into_file && dSel);
  c_move_file_to_dest_test: cover property (@(posedge ref_clk) disable iff (!rstn)
    stExec && op == move_file_to_dest && dSel);
  c_rot_cy: cover property (@(posedge ref_clk) disable iff (!rstn)
    stExec && op == rotate_left_through_carry && opnd[7]);
  c_return: cover property (@(posedge ref_clk) disable iff (!rstn)
    stExec && op == return_from_interrupt_op && !gie_ff);

endmodule : fmx_exec

// [fmx_pkg.sv]
package fmx_pkg;
  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    FMX_IDLE = 2'b01,
    FMX_EXEC = 2'b10
  } fmx_state_t;
  // Operation codes carried in the instruction register
  typedef enum logic [2:0] {
    or_working_into_file      = 3'h0,
    store_working_to_file     = 3'h1,
    move_file_to_dest         = 3'h2,
    rotate_left_through_carry = 3'h3,
    return_from_interrupt_op  = 3'h4,
    FMX_OP_NONE               = 3'h7
  } fmx_op_t;
endpackage : fmx_pkg

// [test_file_move_or_rotate_exec.sv]
`timescale 1ns/1ps
`include "fmx_defines.svh"
module test_file_move_or_rotate_exec
  import fmx_pkg::*;
;
  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  localparam logic [11:0] AWK = `FMX_OFF_WORK;
  localparam logic [11:0] AST = `FMX_OFF_STATUS;
  logic        ref_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic [11:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [12:0] pcOut;
  logic        globalIntEnable;
  logic        execBusy;
  int          n_fail  = 0;
  int          n_tests = 0;
  int          nBusy   = 0;
  int          nRuns   = 0;

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  // Busy cycles seen; each instruction must give exactly one
  always @(posedge ref_clk) begin
    if (execBusy === 1'b1) begin
      nBusy <= nBusy + 1;
    end
  end

  fmx_exec u_fmx_exec (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pcOut(pcOut),
    .globalIntEnable(globalIntEnable), .execBusy(execBusy));
  fmx_dec_model u_fmx_dec_model (.ref_clk(ref_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_fmx_dec_model.xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_fmx_dec_model.xfer(1'b0, a, 32'h00000000, q);
    chk(q, e);
  endtask : rc

  // File word sits at 0x200 plus four times its number
  function automatic logic [11:0] fa(input logic [6:0] f);
    return 12'h200 + {3'h0, f, 2'b00};
  endfunction : fa

  // Writing the instruction word starts execution
  task automatic run(input fmx_op_t op, input logic d, input logic [6:0] f);
    nRuns++;
    wr(`FMX_OFF_INSTR, {21'h000000, op, d, f});
  endtask : run

  task close_out;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // ------------------------------------------------
  // Tests
  // ------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rc(AWK, 32'h0);
    rc(AST, 32'h0);
    rc(`FMX_OFF_PC, 32'h0);
    wr(12'h018, 32'hffff);  // Unmapped write must vanish
    rc(12'h018, 32'h0);
    // OR into work: zero cleared, carry kept, file untouched
    wr(fa(7'd5), 32'h0c);
    wr(AWK, 32'h30);
    wr(AST, 32'h5);
    run(or_working_into_file, 1'b0, 7'd5);
    rc(AWK, 32'h3c);
    rc(AST, 32'h1);
    rc(fa(7'd5), 32'h0c);
    // OR into top file with zero result
    wr(fa(7'd127), 32'h0);
    wr(AWK, 32'h0);
    run(or_working_into_file, 1'b1, 7'd127);
    rc(fa(7'd127), 32'h0);
    rc(AST, 32'h5);
    // Store work: every flag must stay as it was
    wr(AWK, 32'ha5);
    run(store_working_to_file, 1'b0, 7'd127);
    rc(fa(7'd127), 32'ha5);
    rc(AST, 32'h5);
    // Move file onto itself tests it without change
    run(move_file_to_dest, 1'b1, 7'd127);
    rc(fa(7'd127), 32'ha5);
    rc(AST, 32'h1);
    wr(fa(7'd6), 32'h0);
    run(move_file_to_dest, 1'b0, 7'd6);
    rc(AWK, 32'h0);
    rc(AST, 32'h5);
    // Rotate: carry in at bit 0, bit 7 out; zero flag left alone
    wr(fa(7'd6), 32'h80);
    run(rotate_left_through_carry, 1'b1, 7'd6);
    rc(fa(7'd6), 32'h01);
    rc(AST, 32'h5);
    rc(AWK, 32'h0);
    wr(AST, 32'h0);
    wr(fa(7'd6), 32'h81);
    run(rotate_left_through_carry, 1'b0, 7'd6);
    rc(AWK, 32'h02);
    rc(AST, 32'h1);
    rc(fa(7'd6), 32'h81);
    // Return loads the counter from the stack top with its top bit set
    wr(`FMX_OFF_STACK, 32'h1abc);
    wr(AST, 32'h4);
    run(return_from_interrupt_op, 1'b0, 7'd0);
    rc(`FMX_OFF_PC, 32'h1abc);
    rc(`FMX_OFF_GIE, 32'h1);
    rc(AST, 32'h4);
    chk({19'h0, pcOut}, 32'h1abc);
    chk({31'h0, globalIntEnable}, 32'h1);
    chk(nBusy, nRuns);
    close_out;
  end

  // Watchdog, well past the roughly 140 cycles the tests need
  initial begin
    #20000;
    n_fail++;
    close_out;
  end
endmodule : test_file_move_or_rotate_exec
